/* design/rie_consts.vh */
// Constants of the rotate instruction execution block
// Summary of operation
// - With the destination bit at 0 the result goes to the working register and the file register stays as it was.
// - With the destination bit at 1 the result is written back into the source file register.
// - With the access bit at 0 the operand sits in the access bank and the bank select register is ignored.
// - With the access bit at 1 the bank select register picks the general purpose bank that holds the operand.
// - With the extended set on and the access bit at 0, an address of 95 or less is taken as an offset from the index base.
// - Each rotate is one word and one instruction cycle of four quarters: decode, read, process, write.
// - The right rotate moves the operand one place right through a nine-bit chain that includes the carry.
// - The left rotate without carry moves each bit left, feeds bit 7 into bit 0, touches only N and Z, opcode 0100 01da.
// - The right rotate through carry loads bit 0 into carry, old carry into bit 7, updates C, N and Z, opcode 0011 00da.
// - The operand field is an 8-bit address from 0 to 255 and the destination and access fields are one bit each.
`ifndef RIE_CONSTS_VH
`define RIE_CONSTS_VH

// ****************************************
// Instruction word layout
// ****************************************
`define RIE_OPC_HI        15
`define RIE_OPC_LO        10
`define RIE_DEST_BIT      9
`define RIE_ACC_BIT       8
`define RIE_FADDR_HI      7
`define RIE_FADDR_LO      0

// ****************************************
// Opcodes (upper six bits)
// ****************************************
`define RIE_OP_ROT_LEFT   6'h11
`define RIE_OP_ROT_RIGHT  6'h0c

// ****************************************
// Addressing
// ****************************************
`define RIE_ADDR_W        12
`define RIE_MEM_DEPTH     4096
`define RIE_LOW_LIMIT     8'h5f
`define RIE_LOW_BANK      4'h0
`define RIE_HIGH_BANK     4'hf

// ****************************************
// Reset values
// ****************************************
`define RIE_RST_BYTE      8'h00
`define RIE_RST_ADDR      12'h000
`define RIE_RST_INSTR     16'h0000
`define RIE_RST_FLAG      1'b0

`endif

/* design/rie_exec.v */
// Rotate instruction execution core with file register space
`timescale 1ns/100ps
`default_nettype none
`include "rie_consts.vh"

module rie_exec (
    // Clock and reset
    input  wire                    sys_clk,
    input  wire                    rstn,
    // Instruction issue
    input  wire                    instrValid,
    input  wire [15:0]             instrWord,
    output wire                    instrReady,
    // Addressing configuration
    input  wire                    extEnable,
    input  wire [3:0]              bank_select_reg,
    input  wire [`RIE_ADDR_W-1:0]  indexBase,
    // Preload of working register and carry, idle only
    input  wire                    wLoad,
    input  wire [7:0]              wLoadData,
    input  wire                    carryLoad,
    input  wire                    carryLoadData,
    // File register access from outside, writes idle only
    input  wire                    hostWrEn,
    input  wire [`RIE_ADDR_W-1:0]  hostAddr,
    input  wire [7:0]              hostWrData,
    output wire [7:0]              hostRdData,
    // Architectural state
    output reg  [7:0]              wreg_ff,
    output reg                     carry_ff,
    output reg                     neg_ff,
    output reg                     zero_ff,
    // Progress
    output reg  [2:0]              quarter_ff,
    output reg                     done_ff,
    output reg                     badOp_ff
);

    // ****************************************
    // Sequencer states
    // ****************************************
    localparam [2:0] ST_IDLE = 3'b000;
    localparam [2:0] ST_Q1   = 3'b001;
    localparam [2:0] ST_Q2   = 3'b010;
    localparam [2:0] ST_Q3   = 3'b011;
    localparam [2:0] ST_Q4   = 3'b100;

    reg  [2:0]              nxt_quarter;
    reg  [15:0]             instr_ff;
    reg  [`RIE_ADDR_W-1:0]  opAddr_ff;
    reg  [`RIE_ADDR_W-1:0]  nxt_opAddr;
    reg  [7:0]              result_ff;
    reg                     resCarry_ff;
    reg                     isLeft_ff;
    reg                     isRight_ff;
    reg  [7:0]              nxt_result;
    reg                     nxt_resCarry;
    wire [7:0]              rdData;
    wire [5:0]              opcode;
    wire                    destFile;
    wire                    accBanked;
    wire [7:0]              fAddr;
    wire                    legalOp;
    wire                    memWrEn;
    wire [`RIE_ADDR_W-1:0]  memWrAddr;
    wire [7:0]              memWrData;
    wire [`RIE_ADDR_W-1:0]  memRdAddr;

    // ****************************************
    // Field extraction
    // ****************************************
    // Operand fields: one bit each for d and a, eight for f
    assign opcode   = instr_ff[`RIE_OPC_HI:`RIE_OPC_LO];
    assign destFile = instr_ff[`RIE_DEST_BIT];
    assign accBanked = instr_ff[`RIE_ACC_BIT];
    assign fAddr    = instr_ff[`RIE_FADDR_HI:`RIE_FADDR_LO];
    // Decoded again from the held word so no stale flag can pass
    assign legalOp  = (opcode == `RIE_OP_ROT_LEFT)
                      || (opcode == `RIE_OP_ROT_RIGHT);

    // New instruction only between cycles
    assign instrReady = (quarter_ff == ST_IDLE);

    // ****************************************
    // Quarter sequencer
    // ****************************************
    // Fixed four-quarter walk, no stalls inside an instruction
    always @* begin
        nxt_quarter = quarter_ff;
        case (quarter_ff)
            ST_IDLE: begin
                if (instrValid) begin
                    nxt_quarter = ST_Q1;
                end
            end
            ST_Q1: begin
                nxt_quarter = ST_Q2;
            end
            ST_Q2: begin
                nxt_quarter = ST_Q3;
            end
            ST_Q3: begin
                nxt_quarter = ST_Q4;
            end
            ST_Q4: begin
                nxt_quarter = ST_IDLE;
            end
            default: begin
                nxt_quarter = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // Q1: operand address decode
    // ****************************************
    // Bank choice; index mode only reaches the low part of the access bank
    always @* begin
        nxt_opAddr = opAddr_ff;
        if (quarter_ff == ST_Q1) begin
            if (accBanked) begin
                nxt_opAddr = {bank_select_reg, fAddr};
            end else if (extEnable && (fAddr <= `RIE_LOW_LIMIT)) begin
                nxt_opAddr = indexBase + {4'h0, fAddr};
            end else if (fAddr <= `RIE_LOW_LIMIT) begin
                nxt_opAddr = {`RIE_LOW_BANK, fAddr};
            end else begin
                nxt_opAddr = {`RIE_HIGH_BANK, fAddr};
            end
        end
    end

    // ****************************************
    // Q3: rotate datapath
    // ****************************************
    // Read data is valid in Q3 because the memory output is registered
    always @* begin
        nxt_result   = result_ff;
        nxt_resCarry = resCarry_ff;
        if (quarter_ff == ST_Q3) begin
            if (isLeft_ff) begin
                nxt_result   = {rdData[6:0], rdData[7]};
                nxt_resCarry = carry_ff;
            end else begin
                // Nine-bit chain: carry in at the top, bit 0 out
                nxt_result   = {carry_ff, rdData[7:1]};
                nxt_resCarry = rdData[0];
            end
        end
    end

    // ****************************************
    // Sequencer and datapath registers
    // ****************************************
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            quarter_ff  <= ST_IDLE;
            instr_ff    <= `RIE_RST_INSTR;
            isLeft_ff   <= `RIE_RST_FLAG;
            isRight_ff  <= `RIE_RST_FLAG;
            opAddr_ff   <= `RIE_RST_ADDR;
            result_ff   <= `RIE_RST_BYTE;
            resCarry_ff <= `RIE_RST_FLAG;
        end else begin
            quarter_ff  <= nxt_quarter;
            opAddr_ff   <= nxt_opAddr;
            result_ff   <= nxt_result;
            resCarry_ff <= nxt_resCarry;
            if ((quarter_ff == ST_IDLE) && instrValid) begin
                instr_ff   <= instrWord;
                isLeft_ff  <= (instrWord[`RIE_OPC_HI:`RIE_OPC_LO]
                               == `RIE_OP_ROT_LEFT);
                isRight_ff <= (instrWord[`RIE_OPC_HI:`RIE_OPC_LO]
                               == `RIE_OP_ROT_RIGHT);
            end
        end
    end

    // ****************************************
    // Q4: write destination and flags
    // ****************************************
    // Unknown opcodes finish the cycle but change nothing
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wreg_ff  <= `RIE_RST_BYTE;
            carry_ff <= `RIE_RST_FLAG;
            neg_ff   <= `RIE_RST_FLAG;
            zero_ff  <= `RIE_RST_FLAG;
            done_ff  <= `RIE_RST_FLAG;
            badOp_ff <= `RIE_RST_FLAG;
        end else begin
            done_ff  <= (quarter_ff == ST_Q4);
            badOp_ff <= (quarter_ff == ST_Q4) && !legalOp;
            if ((quarter_ff == ST_Q4) && legalOp) begin
                if (!destFile) begin
                    wreg_ff <= result_ff;
                end
                neg_ff  <= result_ff[7];
                zero_ff <= (result_ff == 8'h00);
                if (isRight_ff) begin
                    carry_ff <= resCarry_ff;
                end
            end else if (quarter_ff == ST_IDLE) begin
                // Preloads only between instructions, never mid-cycle
                if (wLoad) begin
                    wreg_ff <= wLoadData;
                end
                if (carryLoad) begin
                    carry_ff <= carryLoadData;
                end
            end
        end
    end

    // ****************************************
    // File register port sharing
    // ****************************************
    // Core owns the memory during an instruction; host writes are dropped
    assign memWrEn   = ((quarter_ff == ST_Q4) && legalOp && destFile)
                       || ((quarter_ff == ST_IDLE) && hostWrEn);
    assign memWrAddr = (quarter_ff == ST_Q4) ? opAddr_ff : hostAddr;
    assign memWrData = (quarter_ff == ST_Q4) ? result_ff : hostWrData;
    assign memRdAddr = (quarter_ff == ST_Q2) ? opAddr_ff : hostAddr;
    assign hostRdData = rdData;

    rie_file_mem u_file_mem (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .rdAddr    (memRdAddr),
        .rdData_ff (rdData),
        .wrEn      (memWrEn),
        .wrAddr    (memWrAddr),
        .wrData    (memWrData)
    );

endmodule // rie_exec
`default_nettype wire

/* design/rie_file_mem.v */
// File register memory with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "rie_consts.vh"

module rie_file_mem (
    // Clock and reset
    input  wire                    sys_clk,
    input  wire                    rstn,
    // Read port
    input  wire [`RIE_ADDR_W-1:0]  rdAddr,
    output reg  [7:0]              rdData_ff,
    // Write port
    input  wire                    wrEn,
    input  wire [`RIE_ADDR_W-1:0]  wrAddr,
    input  wire [7:0]              wrData
);

    // Storage array, not reset; software must load it
    reg [7:0] memArray [0:`RIE_MEM_DEPTH-1];

    // Write port
    always @(posedge sys_clk) begin
        if (wrEn) begin
            memArray[wrAddr] <= wrData;
        end
    end

    // Read data registered, one cycle of latency
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdData_ff <= `RIE_RST_BYTE;
        end else begin
            rdData_ff <= memArray[rdAddr];
        end
    end

endmodule // rie_file_mem
`default_nettype wire

/* sim/rie_exec_checker.sv */
// Assertion checker for the rotate execution core
`timescale 1ns/100ps
`default_nettype none
`include "rie_consts.vh"

module rie_exec_checker (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rstn,
    // Instruction issue
    input wire logic        instrValid,
    input wire logic [15:0] instrWord,
    input wire logic        instrReady,
    // State and progress
    input wire logic [7:0]  wreg_ff,
    input wire logic        carry_ff,
    input wire logic        neg_ff,
    input wire logic        zero_ff,
    input wire logic [2:0]  quarter_ff,
    input wire logic        done_ff,
    input wire logic        badOp_ff
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // ****************************************
    // Helper: word taken at issue
    // ****************************************
    // Input word may change after issue, so keep our own copy
    logic [15:0] heldWord_ff;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) heldWord_ff <= 16'h0000;
        else if (quarter_ff == 3'h0 && instrValid) heldWord_ff <= instrWord;
    end
    wire heldLeft = (heldWord_ff[15:10] == `RIE_OP_ROT_LEFT);

    // ****************************************
    // Properties
    // ****************************************
    a_take_to_q1: assert property (
        quarter_ff == 3'h0 && instrValid |=> quarter_ff == 3'h1)
        else $error("issue did not enter first quarter");
    a_quarter_walk: assert property (
        quarter_ff == 3'h1 |=> quarter_ff == 3'h2 ##1 quarter_ff == 3'h3
        ##1 quarter_ff == 3'h4 ##1 quarter_ff == 3'h0 && done_ff)
        else $error("quarter sequence broken");
    a_ready_idle: assert property (instrReady == (quarter_ff == 3'h0))
        else $error("ready does not track idle");
    a_done_pulse: assert property (done_ff |=> !done_ff)
        else $error("done longer than one cycle");
    a_flag_value: assert property (
        done_ff && !badOp_ff && !heldWord_ff[9] |->
        neg_ff == wreg_ff[7] && zero_ff == (wreg_ff == 8'h00))
        else $error("flags disagree with result");
    a_left_carry: assert property (done_ff && heldLeft |->
        carry_ff == $past(carry_ff, 5)) else $error("left rotate moved carry");
    a_file_dest_w: assert property (done_ff && heldWord_ff[9] |->
        wreg_ff == $past(wreg_ff, 5)) else $error("file dest changed W");
    a_bad_quiet: assert property (badOp_ff |-> done_ff &&
        {wreg_ff, carry_ff, neg_ff, zero_ff} ==
        $past({wreg_ff, carry_ff, neg_ff, zero_ff}, 5))
        else $error("unknown opcode changed state");
endmodule // rie_exec_checker

bind rie_exec rie_exec_checker chk (.sys_clk(sys_clk), .rstn(rstn),
    .instrValid(instrValid), .instrWord(instrWord), .instrReady(instrReady),
    .wreg_ff(wreg_ff), .carry_ff(carry_ff), .neg_ff(neg_ff),
    .zero_ff(zero_ff), .quarter_ff(quarter_ff), .done_ff(done_ff),
    .badOp_ff(badOp_ff));
`default_nettype wire

/* sim/test_rie_exec.sv */
// Self-checking testbench for the rotate execution core
`timescale 1ns/100ps
`default_nettype none
`include "rie_consts.vh"

module test_rie_exec;
    // Stimulus, all given values at time zero
    logic        sys_clk = 1'b0, rstn = 1'b0, instrValid = 1'b0;
    logic        extEnable = 1'b0, wLoad = 1'b0, carryLoad = 1'b0;
    logic        carryLoadData = 1'b0, hostWrEn = 1'b0;
    logic [15:0] instrWord = 16'h0000;
    logic [3:0]  bank_select_reg = 4'h3;
    logic [11:0] indexBase = 12'h200, hostAddr = 12'h000;
    logic [7:0]  wLoadData = 8'h00, hostWrData = 8'h00;
    // Observed
    wire         instrReady, carry_ff, neg_ff, zero_ff, done_ff, badOp_ff;
    wire  [7:0]  hostRdData, wreg_ff;
    wire  [2:0]  quarter_ff;
    integer      failures = 0, comparisons = 0;
    logic [7:0]  rd;

    rie_exec dut (.sys_clk(sys_clk), .rstn(rstn), .instrValid(instrValid),
        .instrWord(instrWord), .instrReady(instrReady), .extEnable(extEnable),
        .bank_select_reg(bank_select_reg), .indexBase(indexBase),
        .wLoad(wLoad), .wLoadData(wLoadData), .carryLoad(carryLoad),
        .carryLoadData(carryLoadData), .hostWrEn(hostWrEn),
        .hostAddr(hostAddr), .hostWrData(hostWrData), .hostRdData(hostRdData),
        .wreg_ff(wreg_ff), .carry_ff(carry_ff), .neg_ff(neg_ff),
        .zero_ff(zero_ff), .quarter_ff(quarter_ff), .done_ff(done_ff),
        .badOp_ff(badOp_ff));

    // 250 MHz clock
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task check(input string nm, input logic [15:0] seen,
               input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task finish_test;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Idle-only preload of memory, W and carry
    task poke(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        hostWrEn <= 1'b1; hostAddr <= a; hostWrData <= d;
        @(posedge sys_clk);
        hostWrEn <= 1'b0;
    endtask

    task peek(input logic [11:0] a);
        @(posedge sys_clk);
        hostAddr <= a;
        repeat (2) @(posedge sys_clk);
        #1 rd = hostRdData;
    endtask

    task preload(input logic [7:0] w, input logic c);
        @(posedge sys_clk);
        wLoad <= 1'b1; wLoadData <= w; carryLoad <= 1'b1; carryLoadData <= c;
        @(posedge sys_clk);
        wLoad <= 1'b0; carryLoad <= 1'b0;
    endtask

    // Issue one word, wait a bounded time for done, check latency and state
    task exec(input logic [15:0] w, input logic bad, input logic [7:0] expW,
              input logic [2:0] expCnz);
        integer n;
        n = 0;
        @(posedge sys_clk);
        instrValid <= 1'b1; instrWord <= w;
        @(posedge sys_clk);
        instrValid <= 1'b0;
        do begin
            @(posedge sys_clk);
            #1 n++;
        end while (done_ff !== 1'b1 && n < 12);
        // Four quarters: done shows on the fourth edge after the taking one
        check("latency", n, 4);
        check("badOp", badOp_ff, bad);
        check("wreg", wreg_ff, expW);
        check("flags", {carry_ff, neg_ff, zero_ff}, expCnz);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task t_left_banked;
        poke(12'h312, 8'hab); poke(12'h012, 8'h11); preload(8'h55, 1'b1);
        exec({`RIE_OP_ROT_LEFT, 2'b11, 8'h12}, 1'b0, 8'h55, 3'b100);
        peek(12'h312); check("bank mem", rd, 8'h57);
        peek(12'h012); check("access mem", rd, 8'h11);
        $display("left banked done");
    endtask

    task t_right_chain;
        poke(12'h020, 8'he6); poke(12'hfa0, 8'h01); preload(8'h00, 1'b0);
        exec({`RIE_OP_ROT_RIGHT, 2'b00, 8'h20}, 1'b0, 8'h73, 3'b000);
        peek(12'h020); check("w dest mem", rd, 8'he6);
        exec({`RIE_OP_ROT_RIGHT, 2'b10, 8'ha0}, 1'b0, 8'h73, 3'b101);
        peek(12'hfa0); check("high access", rd, 8'h00);
        exec({`RIE_OP_ROT_LEFT, 2'b00, 8'ha0}, 1'b0, 8'h00, 3'b101);
        exec({`RIE_OP_ROT_RIGHT, 2'b00, 8'ha0}, 1'b0, 8'h80, 3'b010);
        $display("right chain done");
    endtask

    task t_indexed;
        poke(12'h25f, 8'h81); poke(12'hf60, 8'h40);
        @(posedge sys_clk);
        extEnable <= 1'b1;
        exec({`RIE_OP_ROT_LEFT, 2'b00, 8'h5f}, 1'b0, 8'h03, 3'b000);
        exec({`RIE_OP_ROT_LEFT, 2'b00, 8'h60}, 1'b0, 8'h80, 3'b010);
        @(posedge sys_clk);
        extEnable <= 1'b0;
        $display("indexed done");
    endtask

    task t_bad_opcode;
        preload(8'h5a, 1'b1);
        // N stays set from the last rotate, which left 8'h80
        exec(16'hffff, 1'b1, 8'h5a, 3'b110);
        $display("bad opcode done");
    endtask

    // Watchdog, far beyond the fewer than a hundred cycles the tests need
    initial begin
        #40000;
        failures++;
        finish_test;
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        #1 check("ready in reset", {instrReady, quarter_ff}, 4'h8);
        @(posedge sys_clk);
        rstn <= 1'b1;
        t_left_banked;
        t_right_chain;
        t_indexed;
        t_bad_opcode;
        finish_test;
    end
endmodule // test_rie_exec
`default_nettype wire
